//--- hw/vphy_regs_pkg.sv
/*
 * Constants for the emulated PHY identifier and advertisement register bank:
 * offsets, management indices, field positions, write masks and reset values.
 * Assumes nothing of its surroundings; the management slave and bank files refer to it by name.
 */
package vphy_regs_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Word offsets on the 32-bit register port and indices on the management port
   localparam logic [9:0] OFFSET_IDENT_HIGH = 10'h1C8;
   localparam logic [9:0] OFFSET_IDENT_LOW = 10'h1CC;
   localparam logic [9:0] OFFSET_ADVERT = 10'h1D0;
   localparam logic [4:0] INDEX_IDENT_HIGH = 5'h02;
   localparam logic [4:0] INDEX_IDENT_LOW = 5'h03;
   localparam logic [4:0] INDEX_ADVERT = 5'h04;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Identifier low half fields; write mask and reset values for both halves
   localparam int OUI_LSB_POS = 10;
   localparam int MODEL_POS = 4;
   localparam int REVISION_POS = 0;
   localparam logic [15:0] IDENT_WRITE_MASK = 16'hFFFF;
   localparam logic [15:0] IDENT_HIGH_RESET = 16'h0000;
   localparam logic [15:0] IDENT_LOW_RESET = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Advertisement fields
   localparam int NEXT_PAGE_POS = 15;
   localparam int REMOTE_FAULT_POS = 13;
   localparam int ASYM_PAUSE_POS = 11;
   localparam int SYM_PAUSE_POS = 10;
   localparam int T4_POS = 9;
   localparam int SELECTOR_POS = 0;
   localparam logic [15:0] ADVERT_WRITE_MASK = 16'h0DFF;
   localparam logic [15:0] ADVERT_RESET = 16'h01E1;
   localparam logic [4:0] SELECTOR_IEEE = 5'h01;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Management frame
   localparam logic [5:0] PREAMBLE_ONES = 6'h20;
   localparam logic [5:0] HEADER_BITS = 6'h0D;
   localparam logic [5:0] DATA_BITS = 6'h10;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h01;

   // Keeps the writable bits of new and the fixed bits of old
   function automatic logic [15:0] merge_masked(input logic [15:0] old_val,
                                                 input logic [15:0] new_val,
                                                 input logic [15:0] mask);
      merge_masked = (old_val & ~mask) | (new_val & mask);
   endfunction : merge_masked

endpackage : vphy_regs_pkg

//--- hw/vphy_reg_if.sv
/*
 * Carrier between the register bank and its two internal writers: the serial
 * management slave and the advertisement loader. Single clock domain.
 */
interface vphy_reg_if;
   logic mgmt_we;
   logic [4:0] mgmt_idx;
   logic [15:0] mgmt_wdata;
   logic [15:0] mgmt_rdata;
   logic load_we;
   logic [15:0] load_data;

   modport mgmt_port (output mgmt_we, output mgmt_idx, output mgmt_wdata, input mgmt_rdata);
   modport load_port (output load_we, output load_data);
   modport bank (input mgmt_we, input mgmt_idx, input mgmt_wdata, output mgmt_rdata,
                 input load_we, input load_data);
endinterface : vphy_reg_if

//--- hw/vphy_adv_loader.sv
/*
 * Advertisement loader: after reset release and on each reload pulse it asks
 * the EEPROM side for a word and writes the whole advertisement register.
 * Assumes the EEPROM side answers ee_req with a one-cycle ee_ack and data.
 */
module vphy_adv_loader (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   // Reload command and EEPROM side
   input wire logic reload,
   output logic ee_req,
   input wire logic ee_ack,
   input wire logic [15:0] ee_data,
   // Bank side
   vphy_reg_if.load_port bus
);

   typedef enum logic [1:0] {LD_IDLE, LD_REQ} ld_state_t;
   typedef struct packed {
      ld_state_t state;
      logic req;
      logic we;
      logic [15:0] data;
   } ld_t;

   ld_t s_reg;
   ld_t s_next;

   ////////////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      s_next.we = 1'b0;
      case (s_reg.state)
         LD_IDLE: begin
            if (reload) begin
               s_next.state = LD_REQ;
               s_next.req = 1'b1;
            end
         end
         LD_REQ: begin
            if (ee_ack) begin
               s_next.state = LD_IDLE;
               s_next.req = 1'b0;
               s_next.we = 1'b1;
               s_next.data = ee_data;
            end
         end
         default: begin
            s_next.state = LD_IDLE;
            s_next.req = 1'b0;
         end
      endcase
   end

   // Reset leaves a request pending, so the load follows every release
   always_ff @(posedge mclk) begin
      if (srst) begin
         s_reg <= '{state: LD_REQ, req: 1'b1, we: 1'b0, data: 16'h0000};
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign ee_req = s_reg.req;
   assign bus.load_we = s_reg.we;
   assign bus.load_data = s_reg.data;

endmodule : vphy_adv_loader

//--- hw/vphy_mgmt_slave.sv
/*
 * Serial management slave: 32 preamble ones, start, opcode, PHY and register
 * address, turnaround and 16 data bits, sampled on rising management clock.
 * Assumes the host toggles mdc no faster than a quarter of mclk.
 */
module vphy_mgmt_slave #(
   parameter logic [4:0] PHY_ADDR = vphy_regs_pkg::PHY_ADDR_DEFAULT
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   // Management pins
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n,
   // Bank side
   vphy_reg_if.mgmt_port bus
);

   typedef enum logic [2:0] {MS_PRE, MS_HDR, MS_TA, MS_RDATA, MS_WDATA} ms_state_t;
   typedef struct packed {
      logic [1:0] mdc_s;
      logic [1:0] mdio_s;
      logic mdc_last;
      ms_state_t state;
      logic [5:0] cnt;
      logic [15:0] shift;
      logic [4:0] idx;
      logic we;
      logic dout;
      logic oe_n;
   } ms_t;

   ms_t s_reg;
   ms_t s_next;
   logic rise;
   logic bit_in;

   ////////////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      s_next.mdc_s = {s_reg.mdc_s[0], mdc};
      s_next.mdio_s = {s_reg.mdio_s[0], mdio_in};
      s_next.mdc_last = s_reg.mdc_s[1];
      s_next.we = 1'b0;
      rise = s_reg.mdc_s[1] & ~s_reg.mdc_last;
      bit_in = s_reg.mdio_s[1];
      if (rise) begin
         case (s_reg.state)
            MS_PRE: begin
               if (bit_in) begin
                  if (s_reg.cnt != vphy_regs_pkg::PREAMBLE_ONES) begin
                     s_next.cnt = s_reg.cnt + 6'h01;
                  end
               end else if (s_reg.cnt == vphy_regs_pkg::PREAMBLE_ONES) begin
                  s_next.state = MS_HDR;
                  s_next.cnt = 6'h00;
                  s_next.shift = 16'h0000;
               end else begin
                  s_next.cnt = 6'h00;
               end
            end
            MS_HDR: begin
               // Collects start bit two, opcode, PHY and register address
               s_next.shift = {s_reg.shift[14:0], bit_in};
               s_next.cnt = s_reg.cnt + 6'h01;
               if (s_reg.cnt == vphy_regs_pkg::HEADER_BITS - 6'h01) begin
                  s_next.state = MS_TA;
                  s_next.cnt = 6'h00;
                  s_next.idx = {s_reg.shift[3:0], bit_in};
               end
            end
            MS_TA: begin
               s_next.cnt = s_reg.cnt + 6'h01;
               if (s_reg.shift[12] != 1'b1 || s_reg.shift[9:5] != PHY_ADDR) begin
                  s_next.state = MS_PRE;
                  s_next.cnt = 6'h00;
               end else if (s_reg.shift[11:10] == vphy_regs_pkg::OP_READ) begin
                  if (s_reg.cnt == 6'h00) begin
                     s_next.oe_n = 1'b0;
                     s_next.dout = 1'b0;
                  end else begin
                     s_next.state = MS_RDATA;
                     s_next.cnt = 6'h00;
                     s_next.shift = bus.mgmt_rdata;
                     s_next.dout = bus.mgmt_rdata[15];
                  end
               end else if (s_reg.shift[11:10] == vphy_regs_pkg::OP_WRITE) begin
                  if (s_reg.cnt != 6'h00) begin
                     s_next.state = MS_WDATA;
                     s_next.cnt = 6'h00;
                  end
               end else begin
                  s_next.state = MS_PRE;
                  s_next.cnt = 6'h00;
               end
            end
            MS_RDATA: begin
               s_next.cnt = s_reg.cnt + 6'h01;
               s_next.shift = {s_reg.shift[14:0], 1'b0};
               s_next.dout = s_reg.shift[14];
               if (s_reg.cnt == vphy_regs_pkg::DATA_BITS - 6'h01) begin
                  s_next.state = MS_PRE;
                  s_next.cnt = 6'h00;
                  s_next.oe_n = 1'b1;
                  s_next.dout = 1'b0;
               end
            end
            MS_WDATA: begin
               s_next.cnt = s_reg.cnt + 6'h01;
               s_next.shift = {s_reg.shift[14:0], bit_in};
               if (s_reg.cnt == vphy_regs_pkg::DATA_BITS - 6'h01) begin
                  s_next.state = MS_PRE;
                  s_next.cnt = 6'h00;
                  s_next.we = 1'b1;
               end
            end
            default: begin
               s_next.state = MS_PRE;
               s_next.cnt = 6'h00;
               s_next.oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_reg <= '{mdc_s: 2'h0, mdio_s: 2'h0, mdc_last: 1'b0, state: MS_PRE, cnt: 6'h00,
                    shift: 16'h0000, idx: 5'h00, we: 1'b0, dout: 1'b0, oe_n: 1'b1};
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign mdio_out = s_reg.dout;
   assign mdio_oe_n = s_reg.oe_n;
   assign bus.mgmt_we = s_reg.we;
   assign bus.mgmt_idx = s_reg.idx;
   assign bus.mgmt_wdata = s_reg.shift;

endmodule : vphy_mgmt_slave

//--- hw/vphy_ident_advert_regs.sv
/*
 * Emulated PHY identifier and advertisement register bank with a 32-bit word
 * port, a serial management port and an EEPROM-fed advertisement loader.
 * Assumes reg_req and the EEPROM handshake come from logic on mclk; mdc, mdio
 * and the strap are pins and are synchronised here.
 */
// Overview of operation
// - Identifier low half sits at 0x1CC, index 3; upper 16 bits read zero.
// - Over serial management each register is the low 16 bits only.
// - Identifier low bits 15:10 hold writable OUI low six bits, reset zero.
// - Identifier low bits 9:4 hold writable model number, reset zero.
// - Identifier low bits 3:0 hold writable revision number, reset zero.
// - Advertisement register sits at 0x1D0, index 4.
// - Loader rewrites the whole advertisement after reset release and each reload.
// - Advertisement bit 15, next page, is read-only zero.
// - Advertisement bit 13, remote fault, is read-only zero.
// - Advertisement bits 11 and 10 are writable asymmetric and symmetric pause.
// - Pause bits reset to one when strap low, zero when strap high.
// - Strap is captured at reset release and held afterwards.
// - Advertisement bit 9, 100BASE-T4, is read-only zero.
// - Advertisement bits 8 to 5 are writable abilities resetting to one.
// - Selector field bits 4:0 writable, reset 00001; software writes only that.
// - Identifier high half at 0x1C8 is writable sixteen bits, reset zero.
module vphy_ident_advert_regs #(
   parameter logic [4:0] PHY_ADDR = vphy_regs_pkg::PHY_ADDR_DEFAULT
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   // 32-bit register word port
   input wire logic reg_req,
   input wire logic reg_wr,
   input wire logic [9:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_ack,
   // Serial management pins
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n,
   // Strap and EEPROM loader
   input wire logic flow_control_default_strap,
   input wire logic reload,
   output logic ee_req,
   input wire logic ee_ack,
   input wire logic [15:0] ee_data,
   // Register contents for the negotiation logic
   output logic [31:0] ident_word,
   output logic [15:0] advert_word
);

   typedef struct packed {
      logic [1:0] strap_s;
      logic strap;
      logic strap_pending;
      logic [15:0] ident_high;
      logic [15:0] ident_low;
      logic [15:0] advert;
      logic [31:0] rdata;
      logic ack;
   } bank_t;

   bank_t s_reg;
   bank_t s_next;
   vphy_reg_if link ();

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Writers
   vphy_mgmt_slave #(.PHY_ADDR(PHY_ADDR)) mgmt_u (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .mdc(mdc),
      .mdio_in(mdio_in),
      .mdio_out(mdio_out),
      .mdio_oe_n(mdio_oe_n),
      .bus(link.mgmt_port)
   );

   vphy_adv_loader loader_u (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .reload(reload),
      .ee_req(ee_req),
      .ee_ack(ee_ack),
      .ee_data(ee_data),
      .bus(link.load_port)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [15:0] read_index(input bank_t b, input logic [4:0] idx);
      case (idx)
         vphy_regs_pkg::INDEX_IDENT_HIGH: read_index = b.ident_high;
         vphy_regs_pkg::INDEX_IDENT_LOW: read_index = b.ident_low;
         vphy_regs_pkg::INDEX_ADVERT: read_index = b.advert;
         default: read_index = 16'h0000;
      endcase
   endfunction : read_index

   function automatic logic [4:0] index_of(input logic [9:0] addr);
      case (addr)
         vphy_regs_pkg::OFFSET_IDENT_HIGH: index_of = vphy_regs_pkg::INDEX_IDENT_HIGH;
         vphy_regs_pkg::OFFSET_IDENT_LOW: index_of = vphy_regs_pkg::INDEX_IDENT_LOW;
         vphy_regs_pkg::OFFSET_ADVERT: index_of = vphy_regs_pkg::INDEX_ADVERT;
         default: index_of = 5'h1F;
      endcase
   endfunction : index_of

   // Applies a 16-bit write to one register through its writable mask
   function automatic bank_t write_index(input bank_t b, input logic [4:0] idx,
                                         input logic [15:0] data);
      bank_t r;
      r = b;
      case (idx)
         vphy_regs_pkg::INDEX_IDENT_HIGH: begin
            r.ident_high = vphy_regs_pkg::merge_masked(b.ident_high, data,
                                                      vphy_regs_pkg::IDENT_WRITE_MASK);
         end
         vphy_regs_pkg::INDEX_IDENT_LOW: begin
            r.ident_low = vphy_regs_pkg::merge_masked(b.ident_low, data,
                                                     vphy_regs_pkg::IDENT_WRITE_MASK);
         end
         vphy_regs_pkg::INDEX_ADVERT: begin
            r.advert = vphy_regs_pkg::merge_masked(b.advert, data,
                                                  vphy_regs_pkg::ADVERT_WRITE_MASK);
         end
         default: begin
            r = b;
         end
      endcase
      write_index = r;
   endfunction : write_index

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next state: loader over word port over management port
   always_comb begin
      s_next = s_reg;
      s_next.strap_s = {s_reg.strap_s[0], flow_control_default_strap};
      s_next.ack = 1'b0;
      if (s_reg.strap_pending) begin
         s_next.strap_pending = 1'b0;
         s_next.advert[vphy_regs_pkg::ASYM_PAUSE_POS] = ~s_reg.strap;
         s_next.advert[vphy_regs_pkg::SYM_PAUSE_POS] = ~s_reg.strap;
      end
      if (link.mgmt_we) begin
         s_next = write_index(s_next, link.mgmt_idx, link.mgmt_wdata);
      end
      if (reg_req && reg_wr) begin
         s_next = write_index(s_next, index_of(reg_addr), reg_wdata[15:0]);
      end
      if (link.load_we) begin
         s_next.advert = link.load_data & vphy_regs_pkg::ADVERT_WRITE_MASK;
      end
      if (reg_req) begin
         s_next.ack = 1'b1;
         s_next.rdata = {16'h0000, read_index(s_reg, index_of(reg_addr))};
      end
   end

   // Strap follows its synchroniser through reset; the last value is kept
   always_ff @(posedge mclk) begin
      if (srst) begin
         s_reg.strap_s <= {s_reg.strap_s[0], flow_control_default_strap};
         s_reg.strap <= s_reg.strap_s[1];
         s_reg.strap_pending <= 1'b1;
         s_reg.ident_high <= vphy_regs_pkg::IDENT_HIGH_RESET;
         s_reg.ident_low <= vphy_regs_pkg::IDENT_LOW_RESET;
         s_reg.advert <= vphy_regs_pkg::ADVERT_RESET;
         s_reg.rdata <= 32'h00000000;
         s_reg.ack <= 1'b0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign link.mgmt_rdata = read_index(s_reg, link.mgmt_idx);
   assign reg_rdata = s_reg.rdata;
   assign reg_ack = s_reg.ack;
   assign ident_word = {s_reg.ident_high, s_reg.ident_low};
   assign advert_word = s_reg.advert;

endmodule : vphy_ident_advert_regs

//--- bench/vphy_regs_props.sv
/*
 * Concurrent checks on the ports of the identifier and advertisement bank.
 * Assumes one mclk domain and ce held high by the bench.
 */
module vphy_regs_props (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   // Word port
   input wire logic reg_req,
   input wire logic reg_wr,
   input wire logic [9:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_ack,
   // Strap, loader and contents
   input wire logic flow_control_default_strap,
   input wire logic ee_req,
   input wire logic ee_ack,
   input wire logic [15:0] ee_data,
   input wire logic [31:0] ident_word,
   input wire logic [15:0] advert_word
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   localparam logic [15:0] M = vphy_regs_pkg::ADVERT_WRITE_MASK;

   ////////////////////////////////////////////////////////////////////////////////
   a_rdata_upper: assert property (reg_ack |-> reg_rdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   a_read_ident: assert property (reg_req && !reg_wr && ce
      && reg_addr == vphy_regs_pkg::OFFSET_IDENT_LOW
      |=> reg_rdata == {16'h0000, $past(ident_word[15:0])})
      else $error("identifier read mismatch");
   a_read_advert: assert property (reg_req && !reg_wr && ce
      && reg_addr == vphy_regs_pkg::OFFSET_ADVERT
      |=> reg_rdata == {16'h0000, $past(advert_word)})
      else $error("advertisement read mismatch");
   a_next_page: assert property (advert_word[15] == 1'b0)
      else $error("next page bit set");
   a_fault_zero: assert property (advert_word[13] == 1'b0)
      else $error("remote fault bit set");
   a_t4_zero: assert property (advert_word[9] == 1'b0)
      else $error("t4 bit set");
   a_advert_write: assert property (reg_req && reg_wr && ce && !$past(srst)
      && !$past(ee_ack) && reg_addr == vphy_regs_pkg::OFFSET_ADVERT
      |=> advert_word == (($past(advert_word) & ~M) | ($past(reg_wdata[15:0]) & M)))
      else $error("advertisement write mismatch");
   a_ident_write: assert property (reg_req && reg_wr && ce
      && reg_addr == vphy_regs_pkg::OFFSET_IDENT_LOW
      |=> ident_word[15:0] == $past(reg_wdata[15:0]))
      else $error("identifier write mismatch");
   a_loader_word: assert property (ee_req && ee_ack
      |-> ##2 advert_word == ($past(ee_data, 2) & M))
      else $error("loader word not stored");
   a_ee_hold: assert property (ee_req && !ee_ack |=> ee_req)
      else $error("loader request dropped");
   a_strap_pause: assert property ($fell(srst)
      |=> advert_word[11:10] == {2{!$past(flow_control_default_strap, 4)}})
      else $error("pause defaults wrong");
endmodule : vphy_regs_props

bind vphy_ident_advert_regs vphy_regs_props u_props (
   .mclk(mclk), .srst(srst), .ce(ce), .reg_req(reg_req), .reg_wr(reg_wr),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
   .flow_control_default_strap(flow_control_default_strap), .ee_req(ee_req),
   .ee_ack(ee_ack), .ee_data(ee_data), .ident_word(ident_word), .advert_word(advert_word)
);

//--- bench/mgmt_host.sv
/*
 * Management host model: sends clause-22 frames on mdc and mdio.
 * Assumes mclk from the bench; the mdio wire has a pull-up.
 */
module mgmt_host (
   // Clock
   input wire logic mclk,
   // Management wire
   output logic mdc,
   output logic mdio_in,
   input wire logic mdio_out,
   input wire logic mdio_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic drv = 1'b0;
   logic val = 1'b1;

   // Wire level from host, slave or pull-up
   assign mdio_in = drv ? val : (!mdio_oe_n ? mdio_out : 1'b1);
   initial mdc = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Four mclk per half period of mdc
   task automatic half;
      repeat (4) @(posedge mclk);
      #1;
   endtask : half

   task automatic bit_out(input logic b, input logic own);
      drv = own;
      val = b;
      half();
      mdc = 1'b1;
      half();
      mdc = 1'b0;
   endtask : bit_out

   task automatic frame(input logic wr, input logic [4:0] phy, input logic [4:0] idx,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] v;
      v = {32'hFFFFFFFF, 2'h1, wr ? vphy_regs_pkg::OP_WRITE : vphy_regs_pkg::OP_READ,
           phy, idx, 2'h2, wd};
      rd = 16'h0000;
      if (wr) begin
         for (int i = 63; i >= 0; i--) bit_out(v[i], 1'b1);
      end else begin
         for (int i = 63; i >= 18; i--) bit_out(v[i], 1'b1);
         bit_out(1'b1, 1'b0);
         bit_out(1'b1, 1'b0);
         for (int i = 15; i >= 0; i--) begin
            half();
            rd[i] = mdio_in;
            mdc = 1'b1;
            half();
            mdc = 1'b0;
         end
      end
      bit_out(1'b1, 1'b0);
   endtask : frame
endmodule : mgmt_host

//--- bench/tb.sv
/*
 * Self-checking bench for the identifier and advertisement bank.
 * Assumes the management host model and the bound checker.
 */
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, srst, ce, reg_req, reg_wr, reg_ack, mdc, mdio_in, mdio_out, mdio_oe_n;
   logic strap, reload, ee_req, ee_ack;
   logic [9:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, ident_word;
   logic [15:0] ee_data, advert_word, rd16;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;

   vphy_ident_advert_regs DUT (.mclk(mclk), .srst(srst), .ce(ce), .reg_req(reg_req),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
      .mdio_oe_n(mdio_oe_n), .flow_control_default_strap(strap), .reload(reload),
      .ee_req(ee_req), .ee_ack(ee_ack), .ee_data(ee_data), .ident_word(ident_word),
      .advert_word(advert_word));
   mgmt_host host (.mclk(mclk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
      .mdio_oe_n(mdio_oe_n));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      if (fail_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test

   // Hang guard: about 2150 cycles expected
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end

   task automatic tick;
      @(posedge mclk);
      #1;
   endtask : tick

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk

   task automatic rd(input logic [9:0] a, input logic [31:0] exp);
      tick();
      reg_req = 1'b1;
      reg_wr = 1'b0;
      reg_addr = a;
      tick();
      chk({31'h0, reg_ack}, 32'h1);
      chk(reg_rdata, exp);
      reg_req = 1'b0;
   endtask : rd

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      tick();
      reg_req = 1'b1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      tick();
      chk({31'h0, reg_ack}, 32'h1);
      reg_req = 1'b0;
   endtask : wr

   // EEPROM side: one word per pending request, then time to land
   task automatic ee_give(input logic [15:0] w);
      int n;
      n = 0;
      tick();
      while (ee_req !== 1'b1 && n < 100) begin
         tick();
         n++;
      end
      chk({31'h0, ee_req}, 32'h1);
      ee_ack = 1'b1;
      ee_data = w;
      tick();
      ee_ack = 1'b0;
      tick();
      chk({31'h0, ee_req}, 32'h0);
   endtask : ee_give

   task automatic reset;
      srst = 1'b1;
      repeat (4) tick();
      srst = 1'b0;
   endtask : reset

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      srst = 1'b1;
      ce = 1'b1;
      reg_req = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 10'h000;
      reg_wdata = 32'h00000000;
      strap = 1'b0;
      reload = 1'b0;
      ee_ack = 1'b0;
      ee_data = 16'h0000;
      reset();
      rd(vphy_regs_pkg::OFFSET_ADVERT, 32'h00000DE1);
      rd(vphy_regs_pkg::OFFSET_IDENT_LOW, 32'h00000000);
      rd(vphy_regs_pkg::OFFSET_IDENT_HIGH, 32'h00000000);
      ee_give(16'hF2A1);
      rd(vphy_regs_pkg::OFFSET_ADVERT, 32'h000000A1);
      wr(vphy_regs_pkg::OFFSET_ADVERT, 32'hFFFF0001);
      rd(vphy_regs_pkg::OFFSET_ADVERT, 32'h00000001);
      wr(vphy_regs_pkg::OFFSET_ADVERT, 32'hFFFFFFE1);
      rd(vphy_regs_pkg::OFFSET_ADVERT, 32'h00000DE1);
      wr(vphy_regs_pkg::OFFSET_IDENT_LOW, 32'hFFFFABCD);
      rd(vphy_regs_pkg::OFFSET_IDENT_LOW, 32'h0000ABCD);
      wr(vphy_regs_pkg::OFFSET_IDENT_HIGH, 32'h00001234);
      chk(ident_word, 32'h1234ABCD);
      wr(10'h1D4, 32'h00005555);
      rd(10'h1D4, 32'h00000000);
      rd(vphy_regs_pkg::OFFSET_ADVERT, 32'h00000DE1);
      host.frame(1'b0, 5'h01, vphy_regs_pkg::INDEX_IDENT_LOW, 16'h0000, rd16);
      chk({16'h0000, rd16}, 32'h0000ABCD);
      host.frame(1'b1, 5'h01, vphy_regs_pkg::INDEX_ADVERT, 16'h0421, rd16);
      chk({16'h0000, advert_word}, 32'h00000421);
      host.frame(1'b0, 5'h01, vphy_regs_pkg::INDEX_ADVERT, 16'h0000, rd16);
      chk({16'h0000, rd16}, 32'h00000421);
      host.frame(1'b1, 5'h02, vphy_regs_pkg::INDEX_ADVERT, 16'h0000, rd16);
      chk({16'h0000, advert_word}, 32'h00000421);
      tick();
      reload = 1'b1;
      tick();
      reload = 1'b0;
      ee_give(16'h0C01);
      rd(vphy_regs_pkg::OFFSET_ADVERT, 32'h00000C01);
      strap = 1'b1;
      reset();
      rd(vphy_regs_pkg::OFFSET_ADVERT, 32'h000001E1);
      rd(vphy_regs_pkg::OFFSET_IDENT_LOW, 32'h00000000);
      strap = 1'b0;
      repeat (6) tick();
      chk({16'h0000, advert_word}, 32'h000001E1);
      stop_test();
   end
endmodule : tb
